// ---- design/dose_pkg.sv ----
/*
 * Shared constants and types of the dose monitor serial output block.
 * Assumes a 125 MHz system clock; all cycle counts derive from it.
 */
package dose_pkg;
   // ************************************************
   // Timing
   // ************************************************
   localparam int CLK_HZ = 125_000_000;
   localparam int BAUD = 115_200;
   localparam int BAUD_CYC = CLK_HZ / BAUD;
   localparam int SEC_MS = 1000;
   localparam int SETTLE_MS = 1200;
   localparam int GUARD_US = 150;
   localparam int SEC_CYC_DEF = (CLK_HZ / 1000) * SEC_MS;
   localparam int SETTLE_CYC_DEF = (CLK_HZ / 1000) * SETTLE_MS;
   localparam int GUARD_CYC_DEF = (CLK_HZ / 1_000_000) * GUARD_US;
   localparam int MEAS_S = 10;
   localparam int SENT_PER_MIN = 6;
   // ************************************************
   // Thresholds and sizes
   // ************************************************
   localparam logic [7:0] ALARM_CPS = 8'h46;
   localparam logic [19:0] ERR_MAX = 20'hDBBA0;
   localparam logic [23:0] BCD_MAX = 24'h999999;
   localparam logic [23:0] FW_VERSION = 24'h000100;
   localparam logic [4:0] SENT_LAST = 5'h11;
   localparam int FIFO_DEPTH = 32;
   // ************************************************
   // Characters and commands
   // ************************************************
   localparam logic [7:0] CH_START = 8'h24;
   localparam logic [7:0] CH_SEP = 8'h3B;
   localparam logic [7:0] CH_POINT = 8'h2E;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_DOSE = 8'h36;
   localparam logic [7:0] CH_DREQ = 8'h44;
   localparam logic [7:0] CH_INFO = 8'h46;
   localparam logic [55:0] SUF_COUNT = 56'h20_43_50_2F_31_30_73;
   localparam logic [55:0] SUF_DOSE = 56'h20_20_6D_53_76_2F_68;
   localparam logic [55:0] SUF_INFO = 56'h20_46_57_2F_56_45_52;
   localparam logic [7:0] CMD_DOSE = 8'h64;
   localparam logic [7:0] CMD_RESTART = 8'h6E;
   localparam logic [7:0] CASE_BIT = 8'h20;
   // ************************************************
   // Types
   // ************************************************
   typedef enum logic [1:0] {K_INFO, K_COUNT, K_DOSE, K_DREQ} kind_t;
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } tx_word_t;
endpackage

// ---- design/dose_monitor_serial_out.sv ----
/*
 * Serial output logic of the dose monitor: detector pulse counting,
 * alarm and error flags, sentence generation, byte FIFO, UART transmit
 * with frame flag, and UART receive of single byte requests.
 * Assumes detector pulses and the receive line are asynchronous pins.
 */
`timescale 1ns/1ps

// ************************************************
// Byte FIFO
// ************************************************
module byte_fifo #(
   parameter int W = 9,
   parameter int D = 32
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_r, rd_r;

   assign in_ready = (wr_r - rd_r) != (AW + 1)'(D);
   assign out_valid = wr_r != rd_r;
   assign out_data = mem[rd_r[AW-1:0]];

   // Storage written only when not full
   always_ff @(posedge sys_clk) begin
      if (in_valid && in_ready) begin
         mem[wr_r[AW-1:0]] <= in_data;
      end
   end

   // Pointers carry one extra bit to tell full from empty
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_r <= wr_r + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end
endmodule

// ************************************************
// Top
// ************************************************
// Function
// - Link runs 115200 baud, 8 data bits, no parity, one stop bit.
// - Wait 1.2 s settling, then 10 s measurement before sentence zero.
// - Send firmware info text right after reset, before measured data.
// - Periodic sentences need no command; idle receive line is harmless.
// - Sentences every 10 s; single byte requests answered any time.
// - Count over 1000 ms windows; alarm low within one second.
// - Alarm returns high one second after level drops below threshold.
// - Seventy or more counts per second is the alarm condition.
// - After each 60 s period, error low on zero counts or overload.
// - Error returns high in the next period once condition clears.
// - Frame flag low from before first byte until after last byte.
// - Frame flag low at least 100 us before and after the bits.
// - Count rate converted to millisieverts per hour for dose sentences.
// - Error when a minute sees zero or above 900000 counts.
// - Frame flag released 80 to 350 us after the final byte.
// - Ten second period counted from the crystal timebase.
// - Active low external reset restarts the processing core.
module dose_monitor_serial_out #(
   parameter int SEC_CYC = dose_pkg::SEC_CYC_DEF,
   parameter int SETTLE_CYC = dose_pkg::SETTLE_CYC_DEF,
   parameter int GUARD_CYC = dose_pkg::GUARD_CYC_DEF,
   // Clocks per serial bit; must not exceed 2048 for the bit counters
   parameter int BIT_CYC = dose_pkg::BAUD_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Detector and serial pins
   input wire logic pulse_n,
   input wire logic rxd,
   output logic txd,
   // Status pins
   output logic frame_n,
   output logic alarm_n,
   output logic error_n
);
   typedef enum {TX_IDLE, TX_PRE, TX_SEND, TX_POST} tx_state_t;

   // Digit of a BCD field as an ASCII character
   function automatic logic [7:0] digit(logic [23:0] dg, int n);
      return dose_pkg::CH_ZERO | {4'h0, dg[n*4 +: 4]};
   endfunction

   // BCD increment, saturating at all nines
   function automatic logic [23:0] bcd_inc(logic [23:0] v);
      logic [23:0] r;
      logic c;
      r = v;
      c = 1'b1;
      if (v == dose_pkg::BCD_MAX) begin
         return v;
      end
      for (int n = 0; n < 6; n++) begin
         if (c) begin
            if (v[n*4 +: 4] == 4'h9) begin
               r[n*4 +: 4] = 4'h0;
            end else begin
               r[n*4 +: 4] = v[n*4 +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // Character at position i of a fixed 18 byte sentence
   function automatic logic [7:0] char_at(dose_pkg::kind_t k,
         logic [4:0] i, logic [23:0] dg, logic [7:0] tag);
      logic [55:0] suf;
      logic dose;
      int ii;
      ii = int'(i);
      dose = (k == dose_pkg::K_DOSE) || (k == dose_pkg::K_DREQ);
      suf = (k == dose_pkg::K_COUNT) ? dose_pkg::SUF_COUNT :
            (k == dose_pkg::K_INFO) ? dose_pkg::SUF_INFO :
            dose_pkg::SUF_DOSE;
      if (ii == 0) return dose_pkg::CH_START;
      if (ii == 1) return tag;
      if (ii == 2) return dose_pkg::CH_SEP;
      if (ii == 16) return dose_pkg::CH_CR;
      if (ii == 17) return dose_pkg::CH_LF;
      if (dose && ii == 3) return digit(dg, 5);
      if (dose && ii == 4) return dose_pkg::CH_POINT;
      if (dose && ii <= 9) return digit(dg, 9 - ii);
      if (!dose && ii <= 8) return digit(dg, 8 - ii);
      return suf[8*(15 - ii) +: 8];
   endfunction

   // ************************************************
   // Pin synchronisers
   // ************************************************
   logic [2:0] pulse_sync_r, rx_sync_r;
   logic pulse_lvl_r, pulse_prev_r, rx_lvl_r, rx_prev_r;
   logic count_ev;

   // Three stages; a level counts once the last two agree
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pulse_sync_r <= 3'h7;
         rx_sync_r <= 3'h7;
         pulse_lvl_r <= 1'b1;
         pulse_prev_r <= 1'b1;
         rx_lvl_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         pulse_sync_r <= {pulse_sync_r[1:0], pulse_n};
         rx_sync_r <= {rx_sync_r[1:0], rxd};
         if (pulse_sync_r[1] == pulse_sync_r[2]) pulse_lvl_r <= pulse_sync_r[2];
         if (rx_sync_r[1] == rx_sync_r[2]) rx_lvl_r <= rx_sync_r[2];
         pulse_prev_r <= pulse_lvl_r;
         rx_prev_r <= rx_lvl_r;
      end
   end
   assign count_ev = pulse_prev_r && !pulse_lvl_r;

   // ************************************************
   // Timebase
   // ************************************************
   logic [27:0] settle_cnt_r, sec_cnt_r;
   logic running_r, restart_r;
   logic [3:0] sec_in_ten_r;
   logic [2:0] idx_r;
   logic sec_tick, ten_tick, min_end;

   assign sec_tick = running_r && (sec_cnt_r == 28'(SEC_CYC - 1));
   assign ten_tick = sec_tick && (sec_in_ten_r == 4'(dose_pkg::MEAS_S - 1));
   assign min_end = ten_tick &&
                    (idx_r == 3'(dose_pkg::SENT_PER_MIN - 1));

   // Settling delay then free running crystal derived seconds
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         settle_cnt_r <= '0;
         running_r <= 1'b0;
         sec_cnt_r <= '0;
         sec_in_ten_r <= '0;
         idx_r <= '0;
      end else if (!running_r) begin
         settle_cnt_r <= settle_cnt_r + 28'h0000001;
         running_r <= settle_cnt_r == 28'(SETTLE_CYC - 1);
      end else if (restart_r) begin
         sec_cnt_r <= '0;
         sec_in_ten_r <= '0;
         idx_r <= '0;
      end else begin
         sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 28'h0000001;
         if (sec_tick) begin
            sec_in_ten_r <= ten_tick ? '0 : sec_in_ten_r + 4'h1;
         end
         if (ten_tick) begin
            idx_r <= min_end ? '0 : idx_r + 3'h1;
         end
      end
   end

   // ************************************************
   // Counting, alarm and error
   // ************************************************
   logic [23:0] ten_bcd_r, ten_snap_r, min_bcd_r, min_snap_r;
   logic [19:0] min_bin_r;
   logic [7:0] cps_r;
   logic [2:0] cnt_num_r;
   logic alarm_n_r, error_n_r, min_bad;

   assign min_bad = (min_bin_r == '0) || (min_bin_r > dose_pkg::ERR_MAX);

   // Counters restart each window; a pulse on the boundary opens the next
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ten_bcd_r <= '0;
         ten_snap_r <= '0;
         min_bcd_r <= '0;
         min_snap_r <= '0;
         min_bin_r <= '0;
         cps_r <= '0;
         cnt_num_r <= '0;
      end else if (restart_r || !running_r) begin
         ten_bcd_r <= '0;
         min_bcd_r <= '0;
         min_bin_r <= '0;
         cps_r <= '0;
      end else begin
         cps_r <= sec_tick ? {7'h0, count_ev} :
                  (count_ev && cps_r != 8'hFF) ? cps_r + 8'h01 : cps_r;
         ten_bcd_r <= ten_tick ? {23'h0, count_ev} :
                      count_ev ? bcd_inc(ten_bcd_r) : ten_bcd_r;
         // One count per minute is 0.00001 mSv/h, so the BCD minute
         // count is the dose rate with the point after its top digit
         min_bcd_r <= min_end ? {23'h0, count_ev} :
                      count_ev ? bcd_inc(min_bcd_r) : min_bcd_r;
         min_bin_r <= min_end ? {19'h0, count_ev} :
                      (count_ev && min_bin_r != 20'hFFFFF) ?
                      min_bin_r + 20'h00001 : min_bin_r;
         if (ten_tick) begin
            ten_snap_r <= ten_bcd_r;
            cnt_num_r <= idx_r;
         end
         if (min_end) min_snap_r <= min_bcd_r;
      end
   end

   // Alarm judged at each second, decoupled from the minute period
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         alarm_n_r <= 1'b1;
      end else if (sec_tick) begin
         alarm_n_r <= cps_r < dose_pkg::ALARM_CPS;
      end
   end

   // Error judged only at the end of each minute
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         error_n_r <= 1'b1;
      end else if (min_end) begin
         error_n_r <= !min_bad;
      end
   end

   // ************************************************
   // Receiver of single byte requests
   // ************************************************
   logic rx_busy_r, dreq_set;
   logic [10:0] rx_cnt_r;
   logic [3:0] rx_bit_r;
   logic [7:0] rx_sh_r;

   // Mid bit sampling; a start glitch or bad stop drops the byte
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_sh_r <= '0;
         restart_r <= 1'b0;
         dreq_set <= 1'b0;
      end else begin
         restart_r <= 1'b0;
         dreq_set <= 1'b0;
         if (!rx_busy_r) begin
            if (rx_prev_r && !rx_lvl_r) begin
               rx_busy_r <= 1'b1;
               rx_cnt_r <= 11'(BIT_CYC / 2);
               rx_bit_r <= '0;
            end
         end else if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 11'h001;
         end else begin
            rx_cnt_r <= 11'(BIT_CYC - 1);
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && rx_lvl_r) rx_busy_r <= 1'b0;
            if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8) begin
               rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
            end
            if (rx_bit_r == 4'h9) begin
               rx_busy_r <= 1'b0;
               // Requests are case blind; other bytes are ignored
               if (rx_lvl_r && (rx_sh_r | dose_pkg::CASE_BIT) ==
                   dose_pkg::CMD_DOSE) dreq_set <= 1'b1;
               if (rx_lvl_r && (rx_sh_r | dose_pkg::CASE_BIT) ==
                   dose_pkg::CMD_RESTART) restart_r <= 1'b1;
            end
         end
      end
   end

   // ************************************************
   // Sentence generator
   // ************************************************
   logic info_pend_r, cnt_pend_r, dose_pend_r, dreq_pend_r;
   logic gen_active_r, gen_start;
   dose_pkg::kind_t gen_kind_r, pick_kind;
   logic [4:0] gen_idx_r;
   logic [23:0] gen_dg_r;
   logic [7:0] gen_tag_r;
   dose_pkg::tx_word_t fifo_in, fifo_out;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;

   assign gen_start = !gen_active_r &&
      (info_pend_r || cnt_pend_r || dose_pend_r || dreq_pend_r);
   assign pick_kind = info_pend_r ? dose_pkg::K_INFO :
                      cnt_pend_r ? dose_pkg::K_COUNT :
                      dose_pend_r ? dose_pkg::K_DOSE : dose_pkg::K_DREQ;
   // One driver for the whole word: last flag above the character
   assign fifo_in = {gen_idx_r == dose_pkg::SENT_LAST,
                     char_at(gen_kind_r, gen_idx_r, gen_dg_r, gen_tag_r)};

   // Pending requests; a new request wins over the clear on start
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         info_pend_r <= 1'b1;
         cnt_pend_r <= 1'b0;
         dose_pend_r <= 1'b0;
         dreq_pend_r <= 1'b0;
      end else begin
         if (gen_start && pick_kind == dose_pkg::K_INFO) info_pend_r <= 1'b0;
         cnt_pend_r <= ten_tick ||
            (cnt_pend_r && !(gen_start && pick_kind == dose_pkg::K_COUNT));
         dose_pend_r <= min_end ||
            (dose_pend_r && !(gen_start && pick_kind == dose_pkg::K_DOSE));
         dreq_pend_r <= dreq_set ||
            (dreq_pend_r && !(gen_start && pick_kind == dose_pkg::K_DREQ));
      end
   end

   // Writes 18 bytes per sentence, stalling while the FIFO is full
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gen_active_r <= 1'b0;
         gen_kind_r <= dose_pkg::K_INFO;
         gen_idx_r <= '0;
         gen_dg_r <= '0;
         gen_tag_r <= '0;
      end else if (gen_start) begin
         gen_active_r <= 1'b1;
         gen_kind_r <= pick_kind;
         gen_idx_r <= '0;
         case (pick_kind)
            dose_pkg::K_INFO: begin
               gen_dg_r <= dose_pkg::FW_VERSION;
               gen_tag_r <= dose_pkg::CH_INFO;
            end
            dose_pkg::K_COUNT: begin
               gen_dg_r <= ten_snap_r;
               gen_tag_r <= dose_pkg::CH_ZERO | {5'h0, cnt_num_r};
            end
            dose_pkg::K_DOSE: begin
               gen_dg_r <= min_snap_r;
               gen_tag_r <= dose_pkg::CH_DOSE;
            end
            default: begin
               gen_dg_r <= min_snap_r;
               gen_tag_r <= dose_pkg::CH_DREQ;
            end
         endcase
      end else if (gen_active_r && fifo_in_ready) begin
         gen_idx_r <= gen_idx_r + 5'h01;
         if (fifo_in.last) gen_active_r <= 1'b0;
      end
   end

   byte_fifo #(.W(9), .D(dose_pkg::FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .in_valid(gen_active_r),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   // ************************************************
   // Transmitter and frame flag
   // ************************************************
   tx_state_t tx_state_r;
   logic [15:0] guard_r;
   logic [10:0] baud_r;
   logic [3:0] bit_r;
   logic [9:0] shift_r;
   logic busy_r, last_r, txd_r, frame_n_r, bit_end;

   assign bit_end = busy_r && baud_r == 11'(BIT_CYC - 1);
   assign fifo_pop = tx_state_r == TX_SEND && !busy_r && fifo_out_valid;

   // Guard time wraps each packet; a late byte holds the frame open
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_state_r <= TX_IDLE;
         guard_r <= '0;
         baud_r <= '0;
         bit_r <= '0;
         shift_r <= '1;
         busy_r <= 1'b0;
         last_r <= 1'b0;
         txd_r <= 1'b1;
         frame_n_r <= 1'b1;
      end else begin
         case (tx_state_r)
            TX_IDLE: begin
               guard_r <= '0;
               if (fifo_out_valid) begin
                  frame_n_r <= 1'b0;
                  tx_state_r <= TX_PRE;
               end
            end
            TX_PRE: begin
               guard_r <= guard_r + 16'h0001;
               if (guard_r == 16'(GUARD_CYC - 1)) tx_state_r <= TX_SEND;
            end
            TX_SEND: begin
               guard_r <= '0;
               if (fifo_pop) begin
                  shift_r <= {1'b1, fifo_out.data, 1'b0};
                  txd_r <= 1'b0;
                  last_r <= fifo_out.last;
                  busy_r <= 1'b1;
                  baud_r <= '0;
                  bit_r <= '0;
               end else if (bit_end) begin
                  baud_r <= '0;
                  bit_r <= bit_r + 4'h1;
                  shift_r <= {1'b1, shift_r[9:1]};
                  txd_r <= shift_r[1];
                  if (bit_r == 4'h9) begin
                     busy_r <= 1'b0;
                     txd_r <= 1'b1;
                     if (last_r) tx_state_r <= TX_POST;
                  end
               end else if (busy_r) begin
                  baud_r <= baud_r + 11'h001;
               end
            end
            TX_POST: begin
               guard_r <= guard_r + 16'h0001;
               if (guard_r == 16'(GUARD_CYC - 1)) begin
                  frame_n_r <= 1'b1;
                  tx_state_r <= TX_IDLE;
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end

   assign txd = txd_r;
   assign frame_n = frame_n_r;
   assign alarm_n = alarm_n_r;
   assign error_n = error_n_r;

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_txd_in_frame: assert property ($fell(txd_r) |-> !frame_n_r)
      else $error("start bit outside frame");
   a_pre_guard: assert property (tx_state_r == TX_PRE &&
         guard_r == 16'(GUARD_CYC - 1) |=> $past(frame_n_r, 1) == 1'b0
         ##0 $stable(txd_r))
      else $error("pre guard broken");
   a_post_release: assert property ($rose(frame_n_r) |->
         $past(tx_state_r) == TX_POST && txd_r)
      else $error("frame released early");
   a_start_bit: assert property ($fell(txd_r) |-> (!txd_r)[*8])
      else $error("start bit too short");
   a_alarm_set: assert property (sec_tick &&
         cps_r >= dose_pkg::ALARM_CPS |=> !alarm_n_r)
      else $error("alarm not raised");
   a_alarm_clear: assert property (sec_tick &&
         cps_r < dose_pkg::ALARM_CPS |=> alarm_n_r)
      else $error("alarm not released");
   a_error_set: assert property (min_end && min_bad
         |=> !error_n_r ##1 $stable(error_n_r))
      else $error("error not raised");
   a_error_clear: assert property (min_end && !min_bad
         |=> error_n_r)
      else $error("error not released");
   a_settle_quiet: assert property (!running_r |-> !cnt_pend_r)
      else $error("sentence during settling");
   a_info_first: assert property (gen_start &&
         pick_kind == dose_pkg::K_COUNT |-> !info_pend_r)
      else $error("count before info text");

   c_info_sent: cover property (gen_start &&
      pick_kind == dose_pkg::K_INFO);
   c_count_sent: cover property (gen_start &&
      pick_kind == dose_pkg::K_COUNT);
   c_dose_request: cover property (gen_start &&
      pick_kind == dose_pkg::K_DREQ);
   c_alarm_raised: cover property ($fell(alarm_n_r));
endmodule

// ---- verification/host_model.sv ----
/* Host model: serial receiver and frame flag watcher.
   Assumes the bench reads rx_q and n_bad and calls send by hierarchy. */
`timescale 1ns/1ps
// ****************
// Host side
// ****************
module host_model #(
   parameter int GUARD = 40,
   parameter int BIT = dose_pkg::BAUD_CYC
) (
   // Clock and link
   input wire logic sys_clk,
   input wire logic txd,
   input wire logic frame_n,
   output logic rxd
);
   logic [7:0] rx_q[$];
   int n_bad = 0;
   int n_rx = 0;
   int hi_cnt = 0;
   logic rx_drv = 1'b1;
   // Idle high unless a request is sent
   assign rxd = rx_drv;
   // One request byte, 8N1 LSB first, bits changed at falling edges
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_drv = f[i];
         repeat (BIT) @(negedge sys_clk);
      end
   endtask
   // Cycles that txd has stood high
   always @(posedge sys_clk) hi_cnt <= txd ? hi_cnt + 1 : 0;
   // Lead guard before the first start bit
   always @(negedge frame_n) begin : lead
      int k;
      k = 0;
      while (txd === 1'b1 && k < GUARD + 8) begin
         @(posedge sys_clk);
         k++;
      end
      if (k < GUARD || k > GUARD + 4) n_bad++;
   end
   // Trail guard; stop bit counts into hi_cnt
   always @(posedge frame_n) begin
      if (n_rx > 0 && hi_cnt < BIT + GUARD) n_bad++;
   end
   // Mid-bit sampling, LSB first, one stop bit
   always @(negedge txd) begin : rx
      logic [7:0] b;
      if (frame_n !== 1'b0) n_bad++;
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge sys_clk);
         b[i] = txd;
      end
      repeat (BIT) @(posedge sys_clk);
      if (txd !== 1'b1) n_bad++;
      rx_q.push_back(b);
      n_rx++;
   end
endmodule

// ---- verification/testbench.sv ----
/* Bench of the dose monitor output logic.
   Assumes host_model on the link; short second, bit and guard counts. */
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module testbench;
   localparam int SEC = 640;
   localparam int SETL = 500;
   localparam int GRD = 40;
   localparam int BIT = 20;
   localparam int LIMIT = 95000;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic pulse_n = 1'b1;
   logic rxd, txd, frame_n, alarm_n, error_n;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   // Clock, 8 ns period
   always #4 sys_clk = ~sys_clk;
   dose_monitor_serial_out #(.SEC_CYC(SEC), .SETTLE_CYC(SETL),
      .GUARD_CYC(GRD), .BIT_CYC(BIT)) dut_u (.sys_clk(sys_clk),
      .resetn(resetn), .pulse_n(pulse_n), .rxd(rxd), .txd(txd),
      .frame_n(frame_n), .alarm_n(alarm_n), .error_n(error_n));
   host_model #(.GUARD(GRD), .BIT(BIT)) host_u (.sys_clk(sys_clk),
      .txd(txd), .frame_n(frame_n), .rxd(rxd));
   task automatic final_report();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // n detector counts per call, 4 clocks each level
   task automatic pulses(int n);
      repeat (n) begin
         pulse_n = 1'b0;
         repeat (4) @(negedge sys_clk);
         pulse_n = 1'b1;
         repeat (4) @(negedge sys_clk);
      end
   endtask
   // Waits for alarm_n, or error_n when err is set, to reach v
   task automatic wait_for(input logic err, input logic v, input int lim);
      int k;
      k = 0;
      while ((err ? error_n : alarm_n) !== v && k < lim) begin
         @(negedge sys_clk);
         k++;
      end
   endtask
   // Sentence framing; a lost byte reads as 00
   task automatic sentence(string head);
      logic [7:0] b;
      for (int i = 0; i < 18; i++) begin
         b = 8'h00;
         while (host_u.rx_q.size() == 0 && cyc < LIMIT) begin
            @(negedge sys_clk);
         end
         if (host_u.rx_q.size() > 0) b = host_u.rx_q.pop_front();
         if (i < head.len()) check("head", head[i], b);
         if (i == 16) check("cr", 8'h0D, b);
         if (i == 17) check("lf", 8'h0A, b);
      end
   endtask
   // Called on a second boundary: exactly 70 counts alarm, 69 do not
   task automatic t_alarm();
      pulses(70);
      wait_for(1'b0, 1'b0, 2 * SEC + 8);
      check("alarm_n set", 0, alarm_n);
      wait_for(1'b0, 1'b1, 2 * SEC + 8);
      check("alarm_n clear", 1, alarm_n);
      pulses(69);
      wait_for(1'b0, 1'b0, 2 * SEC);
      check("alarm_n 69", 1, alarm_n);
   endtask
   // Minute one has no counts, minute two has some; ends on a tick
   task automatic t_error();
      wait_for(1'b1, 1'b0, 61 * SEC);
      check("error_n set", 0, error_n);
      pulses(5);
      wait_for(1'b1, 1'b1, 61 * SEC);
      check("error_n clear", 1, error_n);
   endtask
   // Dose request during the info text; answer queued right behind it
   task automatic t_request();
      host_u.send(dose_pkg::CMD_DOSE);
      sentence("$F;000100 FW/VER");
      sentence("$D;0.00000 mSv/h");
   endtask
   // Hang guard; a clean run ends near 80400 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      repeat (8) @(negedge sys_clk);
      check("reset outs", 4'hF, {txd, frame_n, alarm_n, error_n});
      resetn = 1'b1;
      t_request();
      t_error();
      t_alarm();
      sentence("$0;000000 CP/10s");
      check("link errors", 0, host_u.n_bad);
      final_report();
   end
endmodule
